/* core/cpmc_unit.v */
// Purpose: One capture/compare/PWM unit with its own 8-bit period timer, APB slave
// Assumes: pclk is the oscillator clock; sleep_in and comparator inputs are on pclk
// Notes: The 16-bit capture/compare timer is outside; it arrives on routed_timer_in
//
// Functional notes
// - Period match clears timer, sets pin unless duty is zero, loads buffer
// - Period is (period+1) times four times prescale
// - Duty writes anytime, loaded only at match
// - Alignment bit picks left or right format
// - Right and left aligned duty bit placement
// - Time base is timer plus two low bits
// - Time base equal duty clears the pin
// - No postscaler affects the PWM period
// - Pulse width is duty times prescaled clock
// - Duty beyond period keeps pin high
// - Resolution grows with period, ten bits max
// - Sleep freezes timer, state and pin
// - Reset restores registers, pin becomes input
// - Control bit 7 enables the unit
// - Control bit 5 reads output, ignores writes
// - Mode field selects function, events set flag
// - Compare codes toggle, set, clear or pulse
// - Compare clear acts on routed timer
// - Capture codes pick edge and edge count
// - Mode off or disable resets output latch
`timescale 1ns/1ns
`default_nettype none
`include "cpmc_consts.vh"

module cpmc_unit #(
	parameter UNIT = 1
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire sleep_in,
	input wire capture_pin_in,
	input wire cmp1_in,
	input wire cmp2_in,
	input wire ioc_in,
	input wire [15:0] routed_timer_in,
	output wire routed_timer_clr,
	output wire unit_io_pin_o,
	output wire unit_io_pin_oe,
	output wire unit_event_flag,
	output wire [1:0] unit_timer_sel
);

// ------------------------------------------------------------
// Address map for this unit
// ------------------------------------------------------------
localparam [11:0] IDX_VAL = (UNIT == 2) ? `CPMC_IDX_VAL2 : `CPMC_IDX_VAL1;
localparam [11:0] IDX_CON = (UNIT == 2) ? `CPMC_IDX_CON2 : `CPMC_IDX_CON1;
localparam [11:0] IDX_TRG = (UNIT == 2) ? `CPMC_IDX_TRG2 : `CPMC_IDX_TRG1;
localparam [11:0] IDX_ROUT = `CPMC_IDX_ROUT;
localparam [11:0] IDX_PER = `CPMC_IDX_PER;
localparam [11:0] IDX_TCON = `CPMC_IDX_TCON;
localparam [11:0] IDX_STAT = `CPMC_IDX_STAT;

// ------------------------------------------------------------
// State
// ------------------------------------------------------------
reg [15:0] val_q;
reg en_q;
reg fmt_q;
reg [3:0] mode_q;
reg [1:0] cts_q;
reg [7:0] rout_q;
reg [7:0] pr_q;
reg [3:0] tcon_q;
reg flag_q;
reg out_q;
reg pulse_q;
reg [7:0] tmr_q;
reg [7:0] psc_q;
reg [9:0] duty_buf_q;
reg sync1_q;
reg sync2_q;
reg sync3_q;
reg pin_q;
reg src_prev_q;
reg [3:0] cap_cnt_q;
reg match_q;
reg clr_q;
reg [31:0] prdata_q;
reg perr_q;

// ------------------------------------------------------------
// Mode decode
// ------------------------------------------------------------
wire run = ~sleep_in;
wire active = en_q & (mode_q != `CPMC_MODE_OFF);
wire is_pwm = active & (mode_q[3:2] == 2'b11);
wire is_cap = active & (mode_q >= `CPMC_MODE_CAPANY) & (mode_q <= `CPMC_MODE_CAPR16);
wire is_cmp = active & ~is_pwm & ~is_cap;
wire clr_mode = (mode_q == `CPMC_MODE_TGLCLR) | (mode_q == `CPMC_MODE_PULSECLR);

// ------------------------------------------------------------
// Prescaler and time base
// ------------------------------------------------------------
reg [7:0] psc_lim;
reg [2:0] psc_sh;

// Timer step is four pclk cycles times the prescale; no postscaler exists
always @* begin
	case (tcon_q[2:1])
		2'b00: begin
			psc_lim = `CPMC_PSC_LIM1;
			psc_sh = 3'd0;
		end
		2'b01: begin
			psc_lim = `CPMC_PSC_LIM4;
			psc_sh = 3'd2;
		end
		2'b10: begin
			psc_lim = `CPMC_PSC_LIM16;
			psc_sh = 3'd4;
		end
		default: begin
			psc_lim = `CPMC_PSC_LIM64;
			psc_sh = 3'd6;
		end
	endcase
end

wire ton = tcon_q[`CPMC_TCON_ON];
wire tick = ton & run & (psc_q >= psc_lim);
wire pr_hit = tick & (tmr_q == pr_q);
wire [7:0] psc_n = (psc_q >= psc_lim) ? 8'h00 : psc_q + 8'h01;
wire [7:0] tmr_n = pr_hit ? 8'h00 : tmr_q + 8'h01;
wire [7:0] psc_low = psc_n >> psc_sh;
// Time base after this edge, so the pin falls as the base reaches the duty
wire [9:0] tbase = {(tick ? tmr_n : tmr_q), psc_low[1:0]};

// Duty value taken from the pair by alignment
wire [9:0] duty_d = fmt_q ? {val_q[15:8], val_q[7:6]} : {val_q[9:8], val_q[7:0]};

// Prescaler and base timer counting
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		psc_q <= 8'h00;
		tmr_q <= 8'h00;
	end else if (ton && run) begin
		psc_q <= psc_n;
		if (tick) tmr_q <= tmr_n;
	end
end

// ------------------------------------------------------------
// Capture input conditioning
// ------------------------------------------------------------
// Pin synchroniser; level accepted once stages two and three agree
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		sync1_q <= 1'b0;
		sync2_q <= 1'b0;
		sync3_q <= 1'b0;
		pin_q <= 1'b0;
	end else begin
		sync1_q <= capture_pin_in;
		sync2_q <= sync1_q;
		sync3_q <= sync2_q;
		if (sync2_q == sync3_q) begin
			pin_q <= sync3_q;
		end
	end
end

reg cap_src;

// Trigger source select
always @* begin
	case (cts_q)
		2'b00: cap_src = pin_q;
		2'b01: cap_src = cmp1_in;
		2'b10: cap_src = cmp2_in;
		default: cap_src = ioc_in;
	endcase
end

wire rise = cap_src & ~src_prev_q;
wire fall = ~cap_src & src_prev_q;
reg cap_hit;

// Capture event by mode
always @* begin
	case (mode_q)
		`CPMC_MODE_CAPANY: cap_hit = rise | fall;
		`CPMC_MODE_CAPFALL: cap_hit = fall;
		`CPMC_MODE_CAPRISE: cap_hit = rise;
		`CPMC_MODE_CAPR4: cap_hit = rise & (cap_cnt_q == `CPMC_CAP_CNT4);
		`CPMC_MODE_CAPR16: cap_hit = rise & (cap_cnt_q == `CPMC_CAP_CNT16);
		default: cap_hit = 1'b0;
	endcase
	cap_hit = cap_hit & is_cap & run;
end

// Edge history follows the source; capture prescaler cleared outside capture
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		src_prev_q <= 1'b0;
		cap_cnt_q <= 4'h0;
	end else if (!is_cap) begin
		src_prev_q <= cap_src;
		cap_cnt_q <= 4'h0;
	end else if (run) begin
		src_prev_q <= cap_src;
		if (cap_hit) begin
			cap_cnt_q <= 4'h0;
		end else if (rise) begin
			cap_cnt_q <= cap_cnt_q + 4'h1;
		end
	end
end

// ------------------------------------------------------------
// Compare match
// ------------------------------------------------------------
wire cmp_eq = is_cmp & (routed_timer_in == val_q);
wire cmp_hit = cmp_eq & ~match_q & run;

// Match history and routed timer clear pulse
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		match_q <= 1'b0;
		clr_q <= 1'b0;
	end else begin
		if (run) begin
			match_q <= cmp_eq;
		end
		clr_q <= cmp_hit & clr_mode;
	end
end

assign routed_timer_clr = clr_q;

// ------------------------------------------------------------
// Output latch and duty buffer
// ------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		out_q <= 1'b0;
		pulse_q <= 1'b0;
		duty_buf_q <= 10'h000;
	end else if (!active) begin
		out_q <= 1'b0;
		pulse_q <= 1'b0;
	end else if (run) begin
		pulse_q <= 1'b0;
		if (is_pwm) begin
			if (pr_hit) begin
				duty_buf_q <= duty_d;
				out_q <= (duty_d != 10'h000);
			end else if (ton && (tbase == duty_buf_q)) begin
				// Never reached if the duty exceeds the period
				out_q <= 1'b0;
			end
		end else if (cmp_hit) begin
			case (mode_q)
				`CPMC_MODE_TGLCLR, `CPMC_MODE_TGL: out_q <= ~out_q;
				`CPMC_MODE_SET: out_q <= 1'b1;
				`CPMC_MODE_CLR: out_q <= 1'b0;
				`CPMC_MODE_PULSE, `CPMC_MODE_PULSECLR: begin
					out_q <= 1'b1;
					pulse_q <= 1'b1;
				end
				default: out_q <= out_q;
			endcase
		end else if (pulse_q) begin
			out_q <= 1'b0; // End of one-cycle pulse
		end
	end
end

// Pin drives only when software turns the driver on and not capturing
assign unit_io_pin_o = out_q;
assign unit_io_pin_oe = tcon_q[`CPMC_TCON_DIR] & ~is_cap;
assign unit_event_flag = flag_q;
assign unit_timer_sel = (UNIT == 2) ? rout_q[3:2] : rout_q[1:0];

// ------------------------------------------------------------
// APB slave
// ------------------------------------------------------------
wire hit_val = (paddr == {2'b00, IDX_VAL, 2'b00});
wire hit_con = (paddr == {2'b00, IDX_CON, 2'b00});
wire hit_trg = (paddr == {2'b00, IDX_TRG, 2'b00});
wire hit_rout = (paddr == {2'b00, IDX_ROUT, 2'b00});
wire hit_per = (paddr == {2'b00, IDX_PER, 2'b00});
wire hit_tcon = (paddr == {2'b00, IDX_TCON, 2'b00});
wire hit_stat = (paddr == {2'b00, IDX_STAT, 2'b00});
wire any_hit = hit_val | hit_con | hit_trg | hit_rout | hit_per | hit_tcon | hit_stat;
wire wr = psel & penable & pwrite;
wire ev_set = (is_pwm & pr_hit) | cmp_hit | cap_hit;
reg [31:0] rd_d;

// Read mux; unmapped reads zero
always @* begin
	rd_d = 32'h00000000;
	if (hit_val) rd_d[15:0] = val_q;
	if (hit_con) rd_d[7:0] = {en_q, 1'b0, out_q, fmt_q, mode_q};
	if (hit_trg) rd_d[1:0] = cts_q;
	if (hit_rout) rd_d[7:0] = rout_q;
	if (hit_per) rd_d[7:0] = pr_q;
	if (hit_tcon) rd_d[3:0] = tcon_q;
	if (hit_stat) rd_d[15:0] = {tmr_q, 7'h00, flag_q};
end

// Read data captured in setup, error flagged for unmapped address
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata_q <= 32'h00000000;
		perr_q <= 1'b0;
	end else if (psel && !penable) begin
		prdata_q <= pwrite ? 32'h00000000 : rd_d;
		perr_q <= ~any_hit;
	end
end

assign prdata = prdata_q;
assign pready = 1'b1;
assign pslverr = psel & penable & perr_q;

// Register writes; capture beats a software write to the value pair
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		val_q <= `CPMC_VAL_RST;
		en_q <= 1'b0;
		fmt_q <= 1'b0;
		mode_q <= `CPMC_MODE_OFF;
		cts_q <= 2'b00;
		rout_q <= `CPMC_ROUT_RST;
		pr_q <= `CPMC_PER_RST;
		tcon_q <= 4'h0;
		flag_q <= 1'b0;
	end else begin
		if (cap_hit) begin
			val_q <= routed_timer_in;
		end else if (wr && hit_val) begin
			val_q <= pwdata[15:0];
		end
		if (wr && hit_con) begin
			en_q <= pwdata[`CPMC_CON_EN];
			fmt_q <= pwdata[`CPMC_CON_FMT];
			mode_q <= pwdata[3:0];
		end
		if (wr && hit_trg) cts_q <= pwdata[1:0];
		if (wr && hit_rout) rout_q <= pwdata[7:0];
		if (wr && hit_per) pr_q <= pwdata[7:0];
		if (wr && hit_tcon) tcon_q <= pwdata[3:0];
		// Event set wins over a write-one clear in the same cycle
		if (ev_set) begin
			flag_q <= 1'b1;
		end else if (wr && hit_stat && pwdata[`CPMC_STAT_FLAG]) begin
			flag_q <= 1'b0;
		end
	end
end

endmodule
`default_nettype wire

/* core/cpmc_consts.vh */
// Purpose: Constants for the capture/compare/PWM unit
// Assumes: Register indices are word indices; byte address is index times four
// Notes: Definitions only
`ifndef CPMC_CONSTS_VH
`define CPMC_CONSTS_VH

// ------------------------------------------------------------
// Register indices
// ------------------------------------------------------------
`define CPMC_IDX_VAL2 12'hFA6
`define CPMC_IDX_CON2 12'hFA8
`define CPMC_IDX_TRG2 12'hFA9
`define CPMC_IDX_VAL1 12'hFAA
`define CPMC_IDX_CON1 12'hFAC
`define CPMC_IDX_TRG1 12'hFAD
`define CPMC_IDX_ROUT 12'hFAE
`define CPMC_IDX_PER 12'hFB0
`define CPMC_IDX_TCON 12'hFB1
`define CPMC_IDX_STAT 12'hFB2

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define CPMC_CON_EN 7
`define CPMC_CON_FMT 4
`define CPMC_TCON_ON 0
`define CPMC_TCON_DIR 3
`define CPMC_STAT_FLAG 0
`define CPMC_ROUT_RST 8'h55
`define CPMC_PER_RST 8'hFF
`define CPMC_VAL_RST 16'h0000

// ------------------------------------------------------------
// Mode codes
// ------------------------------------------------------------
`define CPMC_MODE_OFF 4'h0
`define CPMC_MODE_TGLCLR 4'h1
`define CPMC_MODE_TGL 4'h2
`define CPMC_MODE_CAPANY 4'h3
`define CPMC_MODE_CAPFALL 4'h4
`define CPMC_MODE_CAPRISE 4'h5
`define CPMC_MODE_CAPR4 4'h6
`define CPMC_MODE_CAPR16 4'h7
`define CPMC_MODE_SET 4'h8
`define CPMC_MODE_CLR 4'h9
`define CPMC_MODE_PULSE 4'hA
`define CPMC_MODE_PULSECLR 4'hB

// ------------------------------------------------------------
// Prescaler limits (pclk cycles per timer step minus one) and capture edge counts minus one
// ------------------------------------------------------------
`define CPMC_PSC_LIM1 8'h03
`define CPMC_PSC_LIM4 8'h0F
`define CPMC_PSC_LIM16 8'h3F
`define CPMC_PSC_LIM64 8'hFF
`define CPMC_CAP_CNT4 4'h3
`define CPMC_CAP_CNT16 4'hF

`endif

/* tb/cpmc_monitor.sv */
// Purpose: Port checker for the capture/compare/PWM unit
// Assumes: UNIT is 1
// Notes: Shadows the control register from bus writes
`timescale 1ns/1ns
`default_nettype none
`include "cpmc_consts.vh"
// ------
// Checker
// ------
module cpmc_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic sleep_in,
	input wire logic routed_timer_clr,
	input wire logic unit_io_pin_o,
	input wire logic unit_io_pin_oe,
	input wire logic unit_event_flag
);
	logic [7:0] con_q;
	wire logic wr = psel && penable && pwrite;
	wire logic con_hit = paddr == {2'b00, `CPMC_IDX_CON1, 2'b00};
	wire logic clr_wr = wr && pwdata[0] && paddr == {2'b00, `CPMC_IDX_STAT, 2'b00};
	wire logic pwm = con_q[7] && con_q[3:2] == 2'b11;
	// Control shadow, taken at the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) con_q <= 8'h00;
		else if (wr && con_hit) con_q <= pwdata[7:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rst_idle;
		$rose(presetn) |-> !unit_io_pin_oe && !unit_io_pin_o && !unit_event_flag;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("not idle");
	property p_sleep_hold;
		sleep_in |=> $stable(unit_io_pin_o);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("pin moved");
	property p_off_low;
		!con_q[7] [*3] |-> !unit_io_pin_o;
	endproperty
	a_off_low: assert property (p_off_low) else $error("pin high");
	property p_flag_hold;
		unit_event_flag && !clr_wr |=> unit_event_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
	property p_pwm_flag;
		pwm && $past(pwm) && $rose(unit_io_pin_o) |-> unit_event_flag;
	endproperty
	a_pwm_flag: assert property (p_pwm_flag) else $error("no flag");
	property p_clr_mode;
		routed_timer_clr |-> con_q[7] && (con_q[3:0] == 4'h1 || con_q[3:0] == 4'hB);
	endproperty
	a_clr_mode: assert property (p_clr_mode) else $error("bad clear");
	property p_pulse_one;
		con_q[3:1] == 3'b101 && $rose(unit_io_pin_o) |=> !unit_io_pin_o;
	endproperty
	a_pulse_one: assert property (p_pulse_one) else $error("long pulse");
	property p_ro_out;
		psel && !penable && !pwrite && con_hit |=> prdata[5] == $past(unit_io_pin_o);
	endproperty
	a_ro_out: assert property (p_ro_out) else $error("bad out bit");
	c_pwm: cover property (pwm && $rose(unit_io_pin_o));
	c_clr: cover property (routed_timer_clr);
	c_sleep: cover property (sleep_in ##1 sleep_in);
endmodule
bind cpmc_unit cpmc_monitor u_cpmc_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.sleep_in(sleep_in), .routed_timer_clr(routed_timer_clr), .unit_io_pin_o(unit_io_pin_o),
	.unit_io_pin_oe(unit_io_pin_oe), .unit_event_flag(unit_event_flag));
`default_nettype wire

/* tb/cpmc_load.sv */
// Purpose: Load on the unit's output line
// Assumes: Line is pulled low when not driven
// Notes: Lengths are in pclk cycles
`timescale 1ns/1ns
`default_nettype none
// ------
// Load model
// ------
module cpmc_load (
	input wire logic clk,
	input wire logic rstn,
	input wire logic pin,
	output logic [15:0] hi_len,
	output logic [15:0] per_len
);
	logic pin_q;
	logic [15:0] cnt_q;
	// Rise-to-rise period and high time
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_q <= 1'b0;
			cnt_q <= 16'h0000;
			hi_len <= 16'h0000;
			per_len <= 16'h0000;
		end else begin
			pin_q <= pin;
			cnt_q <= (pin && !pin_q) ? 16'h0001 : cnt_q + 16'h0001;
			if (pin && !pin_q) per_len <= cnt_q;
			if (!pin && pin_q) hi_len <= cnt_q;
		end
	end
endmodule
`default_nettype wire

/* tb/tb_ccp_pwm_mode_control.sv */
// Purpose: Self-checking bench for the capture/compare/PWM unit
// Assumes: UNIT 1, pclk at 20 MHz
// Notes: The load model measures the waveform
`timescale 1ns/1ns
`default_nettype none
`include "cpmc_consts.vh"
// ------
// Bench
// ------
module tb_ccp_pwm_mode_control;
	localparam logic [5:0][3:0] MODES = {4'hB, 4'hA, 4'h1, 4'h2, 4'h9, 4'h8};
	localparam logic [5:0] OUTS = 6'h05;
	localparam logic [5:0] CLRS = 6'h28;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic sleep_in = 1'b0, cap_in = 1'b0, lo = 1'b0, er;
	logic [15:0] paddr = 16'h0000, rt = 16'h0000;
	logic [31:0] pwdata = 32'h0, rd;
	wire logic pready, pslverr, rt_clr, pio, poe, flag;
	wire logic [31:0] prdata;
	wire logic [15:0] hi_len, per_len;
	wire logic [1:0] tsel;
	wire logic pin_lvl = poe ? pio : 1'b0;
	int mismatches = 0, checks = 0, clr_n = 0;
	cpmc_unit #(.UNIT(1)) u_cpmc_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sleep_in(sleep_in), .capture_pin_in(cap_in),
		.cmp1_in(lo), .cmp2_in(lo), .ioc_in(lo), .routed_timer_in(rt), .routed_timer_clr(rt_clr),
		.unit_io_pin_o(pio), .unit_io_pin_oe(poe), .unit_event_flag(flag), .unit_timer_sel(tsel));
	cpmc_load u_cpmc_load (.clk(pclk), .rstn(presetn), .pin(pin_lvl), .hi_len(hi_len),
		.per_len(per_len));
	// Clock and count of clear pulses
	always #25 pclk = ~pclk;
	always @(posedge pclk) clr_n <= clr_n + int'(rt_clr);
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value at %0t: seen %h, expected %h", $time, s, e);
		end
	endtask
	// One bus transfer, held until pready
	task automatic apb(input logic [11:0] i, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wrap_up;
		if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Period 3, then settle over several periods
	task pwm_run(input logic [7:0] ctl, input logic [15:0] val, input logic [7:0] tcon);
		apb(`CPMC_IDX_PER, 1'b1, 32'h3);
		apb(`CPMC_IDX_VAL1, 1'b1, {16'h0, val});
		apb(`CPMC_IDX_CON1, 1'b1, {24'h0, ctl});
		apb(`CPMC_IDX_TCON, 1'b1, {24'h0, tcon});
		repeat (300) @(posedge pclk);
	endtask
	task t_reset;
		apb(`CPMC_IDX_PER, 1'b0, 32'h0);
		chk(rd, {24'h0, `CPMC_PER_RST});
		apb(`CPMC_IDX_ROUT, 1'b0, 32'h0);
		chk(rd, {24'h0, `CPMC_ROUT_RST});
		chk(32'(poe), 32'h0);
		chk(32'(tsel), 32'h1);
		apb(12'hF00, 1'b0, 32'h0);
		chk({rd[30:0], er}, 32'h1);
	endtask
	task t_pwm;
		pwm_run(8'h8C, 16'h0006, 8'h09);
		chk(32'(per_len), 32'h10);
		chk(32'(hi_len), 32'h6);
		pwm_run(8'h9C, 16'h0280, 8'h09);
		chk(32'(hi_len), 32'hA);
		pwm_run(8'h8C, 16'h0006, 8'h0B);
		chk(32'(per_len), 32'h40);
		chk(32'(hi_len), 32'h18);
	endtask
	// Timer count frozen while asleep
	task t_sleep;
		logic [31:0] c;
		sleep_in <= 1'b1;
		apb(`CPMC_IDX_STAT, 1'b0, 32'h0);
		c = rd;
		repeat (40) @(posedge pclk);
		apb(`CPMC_IDX_STAT, 1'b0, 32'h0);
		chk(rd, c);
		sleep_in <= 1'b0;
	endtask
	task t_full;
		pwm_run(8'h8C, 16'h0014, 8'h09);
		repeat (20) begin
			@(posedge pclk);
			chk(32'(pin_lvl), 32'h1);
		end
		apb(`CPMC_IDX_VAL1, 1'b1, 32'h2);
		repeat (40) @(posedge pclk);
		chk(32'(hi_len), 32'h2);
	endtask
	// Disable, with the read-only bit written
	task t_off;
		apb(`CPMC_IDX_CON1, 1'b1, 32'h20);
		repeat (3) @(posedge pclk);
		chk(32'(pio), 32'h0);
		apb(`CPMC_IDX_CON1, 1'b0, 32'h0);
		chk(rd, 32'h0);
	endtask
	// Every compare code against one match
	task t_compare;
		int n0;
		apb(`CPMC_IDX_VAL1, 1'b1, 32'h100);
		for (int i = 0; i < 6; i++) begin
			apb(`CPMC_IDX_CON1, 1'b1, {24'h0, 4'h8, MODES[i]});
			apb(`CPMC_IDX_STAT, 1'b1, 32'h1);
			n0 = clr_n;
			rt <= 16'h0100;
			repeat (4) @(posedge pclk);
			rt <= 16'h0000;
			repeat (2) @(posedge pclk);
			chk(32'(pio), 32'(OUTS[i]));
			chk(32'(flag), 32'h1);
			chk(32'(clr_n - n0), 32'(CLRS[i]));
		end
	endtask
	task t_capture;
		apb(`CPMC_IDX_CON1, 1'b1, 32'h85);
		rt <= 16'h1234;
		cap_in <= 1'b1;
		repeat (10) @(posedge pclk);
		apb(`CPMC_IDX_VAL1, 1'b0, 32'h0);
		chk(rd, 32'h1234);
		apb(`CPMC_IDX_CON1, 1'b1, 32'h84);
		rt <= 16'h5678;
		cap_in <= 1'b0;
		repeat (10) @(posedge pclk);
		apb(`CPMC_IDX_VAL1, 1'b0, 32'h0);
		chk(rd, 32'h5678);
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_pwm;
		t_sleep;
		t_full;
		t_off;
		t_compare;
		t_capture;
		wrap_up;
	end
	// Watchdog against a hang
	initial begin
		repeat (6000) @(posedge pclk);
		mismatches++;
		wrap_up;
	end
endmodule
`default_nettype wire
